/* rtl/ecpc_port.sv */
// Purpose: control register, fifo ports and config registers of the port
// Assumes: host i/o bus is synchronous, one cycle strobes
// Notes:   status, data port and ecr interrupt bits live elsewhere
`timescale 1ns/100ps
`include "ecpc_defs.svh"
module ecpc_port #(
   parameter int FIFO_DEPTH = 16,       // shared fifo depth
   parameter logic [2:0] IRQ_ASSIGN = 3'h0 // irq assignment code
) (
   input  wire logic        clk,            // 50 mhz clock
   input  wire logic        sys_rst,        // async reset, high
   input  wire logic [10:0] io_addr,        // offset from port base
   input  wire logic        io_wr,          // write strobe
   input  wire logic        io_rd,          // read strobe
   input  wire logic [7:0]  io_wdata,       // write data
   output logic [7:0]       io_rdata,       // read data
   input  wire logic [7:0]  dma_data,       // dma byte in
   input  wire logic        dma_valid,      // dma byte offered
   output logic             dma_ready,      // dma byte taken
   input  wire logic        irq_line_level, // level of assigned irq line
   input  wire logic        ack_n_pin,      // acknowledge input
   input  wire logic        busy_pin,       // busy input
   input  wire logic [7:0]  pd_in,          // data lines in
   output logic [7:0]       pd_out,         // data lines out
   output logic             pd_oe,          // data lines driven
   output logic             strobe_pin,     // strobe, low active
   output logic             auto_linefeed_pin, // autofeed, low active
   output logic             init_line_drive,   // init line
   output logic             select_in_pin,  // select-in, low active
   output logic             irq_out,        // interrupt request
   output logic [2:0]       port_mode       // current mode
);
   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [5:0] dcr_reg, dcr_next;        // writable control bits
   logic [7:0] ecr_reg, ecr_next;        // extended control
   logic [2:0] cfgb_low_reg, cfgb_low_next; // writable low bits
   logic       ack_d_reg, ack_d_next;    // ack history
   logic       irq_reg, irq_next;        // irq output
   logic [7:0] rdata_reg, rdata_next;    // read data
   ecpc_pkg::ecpc_mode_t mode;           // decoded mode
   logic       dir_in;                   // effective direction
   ////////////////////////////////////////////////////////////////////////
   // mode and direction decode
   always_comb begin
      mode = ecpc_pkg::ecpc_mode_t'(ecr_reg[7:`ECPC_ECR_MODE_LSB]);
      dir_in = dcr_reg[`ECPC_DCR_DIR_BIT];
      if (mode == ecpc_pkg::MODE_STD || mode == ecpc_pkg::MODE_COMPAT_DATA_FIFO_PORT) begin
         dir_in = 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // shared fifo, two-entry buffer on its feed
   logic       fifo_clr;                 // flush
   logic       fifo_wr, fifo_rd;         // push and pop
   logic [7:0] fifo_wdata, fifo_head;    // data
   logic       fifo_full, fifo_empty;    // flags
   logic [7:0] sk_in, sk_out;            // buffer data
   logic       sk_in_v, sk_in_r;         // buffer input handshake
   logic       sk_out_v;                 // buffer output valid
   logic       host_push, host_pop;      // host fifo port hits
   logic       fwd_mode;                 // fifo drains to lines
   logic       rev_mode;                 // fifo fills from lines
   logic       rx_take;                  // peripheral byte taken
   logic       tx_pop;                   // handshake consumed byte
   assign fifo_clr = (mode == ecpc_pkg::MODE_STD);
   assign host_push = io_wr && io_addr == `ECPC_OFS_FIFO &&
                      (fwd_mode || mode == ecpc_pkg::MODE_TEST);
   assign host_pop = io_rd && io_addr == `ECPC_OFS_FIFO &&
                     ((mode == ecpc_pkg::MODE_ECP && dir_in) ||
                      mode == ecpc_pkg::MODE_TEST);
   assign fwd_mode = !dir_in && (mode == ecpc_pkg::MODE_COMPAT_DATA_FIFO_PORT ||
                     mode == ecpc_pkg::MODE_ECP);
   assign rev_mode = dir_in && mode == ecpc_pkg::MODE_ECP;
   // host write wins over dma in the same cycle; dma waits
   always_comb begin
      sk_in = dma_data;
      sk_in_v = dma_valid && (fwd_mode || mode == ecpc_pkg::MODE_TEST) && !host_push;
      if (host_push) begin
         sk_in = io_wdata;
         sk_in_v = 1'b1;
      end
      if (rx_take) begin
         sk_in = pd_in;
         sk_in_v = 1'b1;
      end
   end
   assign dma_ready = sk_in_r && !host_push && !rx_take &&
                      (fwd_mode || mode == ecpc_pkg::MODE_TEST);
   assign fifo_wr = sk_out_v && !fifo_full;
   assign fifo_wdata = sk_out;
   assign fifo_rd = host_pop || tx_pop;
   ecpc_skid #(
      .W (8)
   ) u_skid (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .clr       (fifo_clr),
      .in_data   (sk_in),
      .in_valid  (sk_in_v),
      .in_ready  (sk_in_r),
      .out_data  (sk_out),
      .out_valid (sk_out_v),
      .out_ready (!fifo_full)
   );
   ecpc_fifo #(
      .W (8),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clr     (fifo_clr),
      .wr      (fifo_wr),
      .wdata   (fifo_wdata),
      .rd      (fifo_rd),
      .rdata   (fifo_head),
      .full    (fifo_full),
      .empty   (fifo_empty)
   );
   ////////////////////////////////////////////////////////////////////////
   // automatic handshake: setup, strobe low, wait busy low
   ecpc_pkg::ecpc_hs_t hs_reg, hs_next;  // handshake state
   logic [7:0] hs_cnt_reg, hs_cnt_next;  // strobe timer
   logic [7:0] hs_data_reg, hs_data_next; // byte on lines
   logic       hs_stb_reg, hs_stb_next;  // hardware strobe
   // the same timed strobe serves compat and ecp forward; ecp
   // reverse takes a byte when the peripheral drops ack
   always_comb begin
      hs_next = hs_reg;
      hs_cnt_next = hs_cnt_reg;
      hs_data_next = hs_data_reg;
      hs_stb_next = 1'b0;
      tx_pop = 1'b0;
      rx_take = 1'b0;
      case (hs_reg)
         ecpc_pkg::HS_IDLE: begin
            if (fwd_mode && !fifo_empty && !busy_pin) begin
               hs_data_next = fifo_head;
               tx_pop = 1'b1;
               hs_cnt_next = 8'(`ECPC_STROBE_CYC);
               hs_next = ecpc_pkg::HS_SETUP;
            end else if (rev_mode && !ack_n_pin && ack_d_reg && sk_in_r) begin
               rx_take = 1'b1;
               hs_next = ecpc_pkg::HS_WAIT;
            end
         end
         ecpc_pkg::HS_SETUP: begin
            hs_next = ecpc_pkg::HS_STROBE;
         end
         ecpc_pkg::HS_STROBE: begin
            hs_stb_next = 1'b1;
            hs_cnt_next = hs_cnt_reg - 8'h01;
            if (hs_cnt_reg == 8'h01) begin
               hs_next = ecpc_pkg::HS_WAIT;
            end
         end
         ecpc_pkg::HS_WAIT: begin
            if (!busy_pin && ack_n_pin) begin
               hs_next = ecpc_pkg::HS_IDLE;
            end
         end
         default: begin
            hs_next = ecpc_pkg::HS_IDLE;
         end
      endcase
      if (!(fwd_mode || rev_mode)) begin
         hs_next = ecpc_pkg::HS_IDLE;
         hs_stb_next = 1'b0;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hs_reg <= ecpc_pkg::HS_IDLE;
         hs_cnt_reg <= 8'h00;
         hs_data_reg <= 8'h00;
         hs_stb_reg <= 1'b0;
      end else begin
         hs_reg <= hs_next;
         hs_cnt_reg <= hs_cnt_next;
         hs_data_reg <= hs_data_next;
         hs_stb_reg <= hs_stb_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // host register writes, ack edge interrupt, read mux
   always_comb begin
      dcr_next = dcr_reg;
      ecr_next = ecr_reg;
      cfgb_low_next = cfgb_low_reg;
      ack_d_next = ack_n_pin;
      irq_next = 1'b0;
      rdata_next = rdata_reg;
      if (io_wr) begin
         case (io_addr)
            `ECPC_OFS_DCR: dcr_next = io_wdata[5:0];
            `ECPC_OFS_ECR: ecr_next = io_wdata;
            `ECPC_OFS_CFGB: begin
               if (mode == ecpc_pkg::MODE_CONF) begin
                  cfgb_low_next = io_wdata[2:0];
               end
            end
            default: begin
            end
         endcase
      end
      // pulse per rising ack edge while enabled
      if (dcr_reg[`ECPC_DCR_IRQEN_BIT] && ack_n_pin && !ack_d_reg) begin
         irq_next = 1'b1;
      end
      if (io_rd) begin
         case (io_addr)
            `ECPC_OFS_DCR: rdata_next = {`ECPC_DCR_FIXED, dcr_reg};
            `ECPC_OFS_ECR: rdata_next = {ecr_reg[7:2], fifo_full, fifo_empty};
            `ECPC_OFS_FIFO: begin
               if (mode == ecpc_pkg::MODE_CONF) begin
                  rdata_next = `ECPC_CFGA_VALUE;
               end else if (host_pop) begin
                  rdata_next = fifo_head;
               end else begin
                  rdata_next = 8'h00;
               end
            end
            `ECPC_OFS_CFGB: begin
               rdata_next = (mode == ecpc_pkg::MODE_CONF) ?
                            {1'b0, irq_line_level, IRQ_ASSIGN, `ECPC_CFGB_LOW}
                            : 8'h00;
            end
            default: rdata_next = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dcr_reg <= 6'h00;
         ecr_reg <= `ECPC_ECR_RESET;
         cfgb_low_reg <= 3'h0;
         ack_d_reg <= 1'b1;
         irq_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         dcr_reg <= dcr_next;
         ecr_reg <= ecr_next;
         cfgb_low_reg <= cfgb_low_next;
         ack_d_reg <= ack_d_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // pin drivers, all registered
   logic [7:0] pd_next;                  // data line value
   logic       oe_next, stb_n, afd_n, init_n, sli_n; // pin next values
   always_comb begin
      pd_next = hs_data_reg;
      if (mode == ecpc_pkg::MODE_TEST) begin
         pd_next = fifo_head;
      end
      oe_next = !dir_in;
      stb_n = !(dcr_reg[0] || hs_stb_reg);
      afd_n = !dcr_reg[1];
      init_n = dcr_reg[2];
      sli_n = !dcr_reg[3];
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pd_out <= 8'h00;
         pd_oe <= 1'b1;
         strobe_pin <= 1'b1;
         auto_linefeed_pin <= 1'b1;
         init_line_drive <= 1'b0;
         select_in_pin <= 1'b1;
         irq_out <= 1'b0;
         port_mode <= 3'h0;
         io_rdata <= 8'h00;
      end else begin
         pd_out <= pd_next;
         pd_oe <= oe_next;
         strobe_pin <= stb_n;
         auto_linefeed_pin <= afd_n;
         init_line_drive <= init_n;
         select_in_pin <= sli_n;
         irq_out <= irq_reg;
         port_mode <= mode;
         io_rdata <= rdata_reg;
      end
   end
endmodule

/* rtl/ecpc_defs.svh */
// Purpose: constants for the parallel port control and fifo block
// Assumes: host i/o register index space is local to this block
// Notes:   offsets are byte indexes relative to the port base
// Summary of operation
// - control bits 7-6 read one, unwritable
// - modes 000/010 force data lines out
// - other modes: bit5 selects data direction
// - ack rise raises irq when enabled
// - select-in pin is inverted control bit3
// - init pin follows control bit2 directly
// - auto-linefeed pin is inverted control bit1
// - strobe pin is inverted control bit0 or handshake strobe
// - mode 010 sends fifo by compat handshake
// - mode 011 dir0 sends fifo by ecp
// - mode 011 dir1 receives bytes into fifo
// - test mode: host fifo access, no transmit
// - config a reads fixed 10h
// - config b bit7 reads zero
// - config b bit6 shows irq line level
// - config b bits 5:3 report irq assignment
// - config b low bits writable, read one
// - mode field is ext control bits 7-5
// - one shared sixteen byte fifo
// - fifo held in reset in mode 000
`ifndef ECPC_DEFS_SVH
`define ECPC_DEFS_SVH
`define ECPC_OFS_DCR       11'h002
`define ECPC_OFS_FIFO      11'h400
`define ECPC_OFS_CFGB      11'h401
`define ECPC_OFS_ECR       11'h402
`define ECPC_CFGA_VALUE    8'h10
`define ECPC_DCR_FIXED     2'h3
`define ECPC_CFGB_LOW      3'h7
`define ECPC_ECR_RESET     8'h15
`define ECPC_ECR_MODE_LSB  5
`define ECPC_DCR_DIR_BIT   5
`define ECPC_DCR_IRQEN_BIT 4
`define ECPC_STROBE_NS     500
`define ECPC_CLK_NS        20
`define ECPC_STROBE_CYC    ((`ECPC_STROBE_NS + `ECPC_CLK_NS - 1) / `ECPC_CLK_NS)
`endif

/* rtl/ecpc_pkg.sv */
// Purpose: shared types for the parallel port control block
// Assumes: used with ecpc_defs.svh
// Notes:   mode encodings follow the extended control mode field
package ecpc_pkg;
   typedef enum logic [2:0] {
      MODE_STD   = 3'h0,  // standard_port_mode
      MODE_PS2   = 3'h1,
      MODE_COMPAT_DATA_FIFO_PORT = 3'h2,
      MODE_ECP   = 3'h3,
      MODE_EPP   = 3'h4,
      MODE_RSVD  = 3'h5,
      MODE_TEST  = 3'h6,
      MODE_CONF  = 3'h7
   } ecpc_mode_t;
   typedef enum logic [1:0] {
      HS_IDLE,
      HS_SETUP,
      HS_STROBE,
      HS_WAIT
   } ecpc_hs_t;
endpackage

/* rtl/ecpc_skid.sv */
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock
// Notes:   ready upstream reflects a free slot, so no stall loses a word
`timescale 1ns/100ps
module ecpc_skid #(
   parameter int W = 8                  // data width
) (
   input  wire logic         clk,       // clock
   input  wire logic         sys_rst,   // async reset
   input  wire logic         clr,       // sync flush
   input  wire logic [W-1:0] in_data,   // incoming word
   input  wire logic         in_valid,  // incoming valid
   output logic              in_ready,  // room available
   output logic [W-1:0]      out_data,  // head word
   output logic              out_valid, // head valid
   input  wire logic         out_ready  // drain accepts
);
   logic [W-1:0] slot_reg [2];          // storage slots
   logic [W-1:0] slot_next [2];         // next slots
   logic [1:0]   cnt_reg, cnt_next;     // occupancy
   ////////////////////////////////////////////////////////////////////////
   // next state: shift on pop, append on push
   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      slot_next = slot_reg;
      cnt_next = cnt_reg;
      push = in_valid && (cnt_reg != 2'h2);
      pop = out_ready && (cnt_reg != 2'h0);
      if (pop) begin
         slot_next[0] = slot_reg[1];
      end
      if (push) begin
         slot_next[(pop ? cnt_reg - 2'h1 : cnt_reg) == 2'h0 ? 0 : 1] = in_data;
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
      if (clr) begin
         cnt_next = 2'h0;
      end
   end
   // registers only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 2'h0;
         slot_reg[0] <= '0;
         slot_reg[1] <= '0;
      end else begin
         cnt_reg <= cnt_next;
         slot_reg <= slot_next;
      end
   end
   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = slot_reg[0];
endmodule

/* rtl/ecpc_fifo.sv */
// Purpose: shared byte fifo behind all fifo ports
// Assumes: single clock, synchronous flush
// Notes:   depth is a power of two
`timescale 1ns/100ps
module ecpc_fifo #(
   parameter int W = 8,                 // data width
   parameter int D = 16                 // depth
) (
   input  wire logic         clk,       // clock
   input  wire logic         sys_rst,   // async reset
   input  wire logic         clr,       // sync flush
   input  wire logic         wr,        // push
   input  wire logic [W-1:0] wdata,     // push data
   input  wire logic         rd,        // pop
   output logic [W-1:0]      rdata,     // head data
   output logic              full,      // no room
   output logic              empty      // nothing held
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];               // storage array
   logic [AW:0]  wp_reg, wp_next;       // write pointer
   logic [AW:0]  rp_reg, rp_next;       // read pointer
   ////////////////////////////////////////////////////////////////////////
   // pointer update, guarded against overflow and underflow
   always_comb begin
      wp_next = wp_reg;
      rp_next = rp_reg;
      if (wr && !full) begin
         wp_next = wp_reg + 1'b1;
      end
      if (rd && !empty) begin
         rp_next = rp_reg + 1'b1;
      end
      if (clr) begin
         wp_next = '0;
         rp_next = '0;
      end
   end
   // pointers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
      end
   end
   // storage has no reset
   always_ff @(posedge clk) begin
      if (wr && !full) begin
         mem[wp_reg[AW-1:0]] <= wdata;
      end
   end
   assign rdata = mem[rp_reg[AW-1:0]];
   assign empty = (wp_reg == rp_reg);
   assign full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
endmodule

/* tb/ecpc_port_assertions.sv */
// Purpose: port-level checks for the control, fifo and config block
// Assumes: bound to ecpc_port, single clock domain
// Notes:   control pin checks only in modes 000/001, where no handshake owns them
`timescale 1ns/100ps
module ecpc_port_chk #(
   parameter logic [2:0] IRQ_ASSIGN = 3'h0   // irq assignment code
) (
   input wire logic        clk,               // clock
   input wire logic        sys_rst,           // async reset, high
   input wire logic [10:0] io_addr,           // register offset
   input wire logic        io_wr,             // write strobe
   input wire logic        io_rd,             // read strobe
   input wire logic [7:0]  io_wdata,          // write data
   input wire logic [7:0]  io_rdata,          // read data
   input wire logic        irq_line_level,    // irq line level
   input wire logic        ack_n_pin,         // acknowledge input
   input wire logic        pd_oe,             // data lines driven
   input wire logic        strobe_pin,        // strobe pin
   input wire logic        auto_linefeed_pin, // autofeed pin
   input wire logic        init_line_drive,   // init pin
   input wire logic        select_in_pin,     // select-in pin
   input wire logic        irq_out,           // interrupt pulse
   input wire logic [2:0]  port_mode          // current mode
);
   logic       ctl_wr;    // control write while software owns the pins
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   assign ctl_wr = io_wr && io_addr == 11'h002 && port_mode < 3'h2;
   ////////////////////////////////////////////////////////////////
   chk_dcr_top_bits: assert property (io_rd && io_addr == 11'h002 |-> ##2 io_rdata[7:6] == 2'h3)
      else $error("control top bits not one");
   chk_dir_forced_out: assert property ((port_mode == 3'h0 || port_mode == 3'h2) [*3] |-> pd_oe)
      else $error("data lines not driven in fixed mode");
   chk_dir_follows_bit: assert property (ctl_wr && port_mode == 3'h1 |-> ##2 pd_oe == !$past(io_wdata[5], 2))
      else $error("data direction does not follow bit 5");
   chk_irq_after_ack: assert property (irq_out |-> $past(ack_n_pin, 2) &&
      !$past(ack_n_pin, 3))
      else $error("interrupt without ack rise");
   chk_irq_one_cycle: assert property (irq_out |=> !irq_out)
      else $error("interrupt pulse longer than one cycle");
   chk_select_pin: assert property (ctl_wr |-> ##2 select_in_pin == !$past(io_wdata[3], 2))
      else $error("select-in pin mismatch");
   chk_init_pin: assert property (ctl_wr |-> ##2 init_line_drive == $past(io_wdata[2], 2))
      else $error("init pin mismatch");
   chk_autofeed_pin: assert property (ctl_wr |-> ##2 auto_linefeed_pin == !$past(io_wdata[1], 2))
      else $error("autofeed pin mismatch");
   chk_strobe_pin: assert property (ctl_wr |-> ##2 strobe_pin == !$past(io_wdata[0], 2))
      else $error("strobe pin mismatch");
   chk_cfga_value: assert property (io_rd && io_addr == 11'h400 && port_mode == 3'h7 |-> ##2 io_rdata == 8'h10)
      else $error("config a value wrong");
   chk_cfgb_fields: assert property (io_rd && io_addr == 11'h401 && port_mode == 3'h7
      |-> ##2 io_rdata == {1'b0, $past(irq_line_level, 2), IRQ_ASSIGN, 3'h7})
      else $error("config b fields wrong");
endmodule

/* tb/ecpc_printer_model.sv */
// Purpose: behavioural printer on the parallel lines
// Assumes: strobe low marks a forward byte, ack pulse a reverse one
// Notes:   idle data lines toggle so stale values are never read as good
`timescale 1ns/100ps
module ecpc_printer_model (
   input  wire logic       clk,               // clock
   input  wire logic       strobe_pin,        // host strobe, low active
   input  wire logic [7:0] pd_out,            // data from host
   output logic            ack_n_pin,         // acknowledge, low active
   output logic            busy_pin,          // busy
   output logic [7:0]      pd_in              // data to host
);
   int         dly = 2;   // ack delay, raised for a slow printer
   bit         rev = 0;   // reverse byte owns the lines
   logic [7:0] rx_q[$];   // bytes taken from the host
   int         n;         // wait bound
   ////////////////////////////////////////////////////////////////
   // forward: take byte on strobe, busy, then ack pulse
   initial begin
      ack_n_pin = 1'b1;
      busy_pin  = 1'b0;
      pd_in     = 8'h5A;
      forever begin
         @(posedge clk);
         if (!rev) begin
            pd_in <= ~pd_in;
         end
         if (!strobe_pin && !rev) begin
            rx_q.push_back(pd_out);
            busy_pin <= 1'b1;
            for (n = 0; n < 200 && !strobe_pin; n++) @(posedge clk);
            repeat (dly) @(posedge clk);
            ack_n_pin <= 1'b0;
            repeat (2) @(posedge clk);
            ack_n_pin <= 1'b1;
            busy_pin  <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // reverse: data first, then a two-cycle ack pulse
   task automatic send(input logic [7:0] b);
      rev = 1;
      @(posedge clk);
      pd_in <= b;
      @(posedge clk);
      ack_n_pin <= 1'b0;
      repeat (2) @(posedge clk);
      ack_n_pin <= 1'b1;
      repeat (2) @(posedge clk);
      rev = 0;
   endtask
endmodule

/* tb/test_ecpc_port.sv */
// Purpose: self-checking bench for the control, fifo and config block
// Assumes: inputs change on the falling edge
// Notes:   irq assignment set non-default to see the field move
`timescale 1ns/100ps
module test_ecpc_port;
   logic        clk, sys_rst, io_wr, io_rd, dma_valid, dma_ready;
   logic        irq_line_level, ack_n_pin, busy_pin, pd_oe, strobe_pin;
   logic        auto_linefeed_pin, init_line_drive, select_in_pin, irq_out;
   logic [10:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, dma_data, pd_in, pd_out;
   logic [2:0]  port_mode;
   int          err_total = 0, checks = 0, irq_cnt = 0, n;
   bit          ok;
   ecpc_port #(.IRQ_ASSIGN(3'h5)) i_ecpc_port (.clk, .sys_rst, .io_addr, .io_wr, .io_rd,
      .io_wdata, .io_rdata, .dma_data, .dma_valid, .dma_ready, .irq_line_level, .ack_n_pin,
      .busy_pin, .pd_in, .pd_out, .pd_oe, .strobe_pin, .auto_linefeed_pin, .init_line_drive,
      .select_in_pin, .irq_out, .port_mode);
   ecpc_printer_model i_ecpc_printer_model (.clk, .strobe_pin,
      .pd_out, .ack_n_pin, .busy_pin, .pd_in);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (irq_out === 1'b1) irq_cnt++;
   initial begin
      #1000000;
      err_total++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   // read data lands two edges after the strobe edge
   task rd(input logic [10:0] a, input logic [7:0] e, input string nm);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      repeat (2) @(negedge clk);
      cmp(nm, e, io_rdata);
   endtask
   task mode(input logic [2:0] m);
      wr(11'h402, {m, 5'h18});
   endtask
   // offer one dma byte; a refusal shows as ok low after the bound
   task dma(input logic [7:0] d, output bit ok);
      int k;
      @(negedge clk);
      dma_data = d;
      dma_valid = 1'b1;
      ok = 0;
      #1;
      for (k = 0; k < 40 && !ok; k++) begin
         if (dma_ready === 1'b1) ok = 1;
         @(negedge clk);
      end
      dma_valid = 1'b0;
   endtask
   task wait_rx(input int c);
      int k;
      for (k = 0; k < 3000 && i_ecpc_printer_model.rx_q.size() < c; k++) @(negedge clk);
      cmp("rx count", 8'(c), 8'(i_ecpc_printer_model.rx_q.size()));
      if (k == 3000) test_done();
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      {io_wr, io_rd, dma_valid, io_addr, io_wdata, dma_data} = '0;
      irq_line_level = 1'b1;
      repeat (12) @(posedge clk);
      @(negedge clk) sys_rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         wr(11'h002, 8'(i));
         repeat (2) @(negedge clk);
         cmp("strobe", {7'h0, ~i[0]}, 8'(strobe_pin));
         cmp("autofeed", {7'h0, ~i[1]}, 8'(auto_linefeed_pin));
         cmp("init", {7'h0, i[2]}, 8'(init_line_drive));
         cmp("select", {7'h0, ~i[3]}, 8'(select_in_pin));
         rd(11'h002, 8'hC0 | 8'(i), "control");
      end
      $display("pins test done");
      mode(3'h1);
      wr(11'h002, 8'h20);
      repeat (2) @(negedge clk);
      cmp("dir in", 8'h00, 8'(pd_oe));
      mode(3'h0);
      repeat (3) @(negedge clk);
      cmp("spp out", 8'h01, 8'(pd_oe));
      mode(3'h2);
      repeat (3) @(negedge clk);
      cmp("compat_data_fifo_port out", 8'h01, 8'(pd_oe));
      $display("direction test done");
      mode(3'h7);
      rd(11'h400, 8'h10, "cfg a");
      rd(11'h401, 8'h6F, "cfg b");
      irq_line_level = 1'b0;
      wr(11'h401, 8'h00);
      rd(11'h401, 8'h2F, "cfg b");
      $display("config test done");
      wr(11'h002, 8'h04);
      mode(3'h6);
      n = 0;
      ok = 1;
      while (ok && n < 24) begin
         dma(8'(8'h30 + n), ok);
         if (ok) n++;
      end
      cmp("fill", 8'h12, 8'(n));
      for (int i = 0; i < n; i++) rd(11'h400, 8'(8'h30 + i), "test_fifo_port");
      wr(11'h400, 8'h11);
      mode(3'h0);
      mode(3'h6);
      wr(11'h400, 8'hA5);
      rd(11'h400, 8'hA5, "flushed");
      $display("fifo test done");
      i_ecpc_printer_model.dly = 8;
      i_ecpc_printer_model.rx_q.delete();
      wr(11'h002, 8'h14);
      mode(3'h2);
      wr(11'h400, 8'h81);
      wr(11'h400, 8'h42);
      dma(8'h24, ok);
      dma(8'h18, ok);
      wait_rx(4);
      cmp("compat", 8'h81, i_ecpc_printer_model.rx_q[0]);
      cmp("compat", 8'h18, i_ecpc_printer_model.rx_q[3]);
      for (n = 0; n < 100 && irq_cnt < 4; n++) @(negedge clk);
      cmp("irq count", 8'h04, 8'(irq_cnt));
      $display("compat test done");
      i_ecpc_printer_model.dly = 1;
      i_ecpc_printer_model.rx_q.delete();
      wr(11'h002, 8'h04);
      mode(3'h1);
      mode(3'h3);
      wr(11'h400, 8'h5A);
      wr(11'h400, 8'hC3);
      wait_rx(2);
      cmp("ecp out", 8'hC3, i_ecpc_printer_model.rx_q[1]);
      repeat (40) @(negedge clk);
      cmp("irq masked", 8'h04, 8'(irq_cnt));
      mode(3'h1);
      wr(11'h002, 8'h24);
      mode(3'h3);
      i_ecpc_printer_model.send(8'h3C);
      i_ecpc_printer_model.send(8'hC3);
      rd(11'h400, 8'h3C, "ecp in");
      rd(11'h400, 8'hC3, "ecp in");
      $display("ecp test done");
      test_done();
   end
endmodule
bind ecpc_port ecpc_port_chk #(.IRQ_ASSIGN(IRQ_ASSIGN)) i_ecpc_port_chk (.clk, .sys_rst,
   .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .irq_line_level, .ack_n_pin, .pd_oe,
   .strobe_pin, .auto_linefeed_pin, .init_line_drive, .select_in_pin, .irq_out, .port_mode);
